// ===== logic/aolsr_consts.svh
// offsets, field positions, reset values, masks and response codes of the register slice
`ifndef AOLSR_CONSTS_SVH
`define AOLSR_CONSTS_SVH
// register indices; the bus byte address is four times the index
`define AOLSR_OFS_OFFSET_CTRL 8'hCF
`define AOLSR_OFS_CHB_LS 8'hDB
`define AOLSR_OFS_BOOST_OVR 8'hEA
`define AOLSR_OFS_LS_SRC 8'hEF
`define AOLSR_OFS_SWING_EN 8'hF1
`define AOLSR_OFS_CHA_LS 8'hF2
`define AOLSR_OFS_STATUS 8'hF8
// byte addresses seen on the 10-bit bus address
`define AOLSR_ADR_OFFSET_CTRL {`AOLSR_OFS_OFFSET_CTRL, 2'b00}
`define AOLSR_ADR_CHB_LS {`AOLSR_OFS_CHB_LS, 2'b00}
`define AOLSR_ADR_BOOST_OVR {`AOLSR_OFS_BOOST_OVR, 2'b00}
`define AOLSR_ADR_LS_SRC {`AOLSR_OFS_LS_SRC, 2'b00}
`define AOLSR_ADR_SWING_EN {`AOLSR_OFS_SWING_EN, 2'b00}
`define AOLSR_ADR_CHA_LS {`AOLSR_OFS_CHA_LS, 2'b00}
`define AOLSR_ADR_STATUS {`AOLSR_OFS_STATUS, 2'b00}
`define AOLSR_RST_VAL 8'h00
`define AOLSR_BIT_HOLD 7
`define AOLSR_TC_LSB 2
`define AOLSR_TC_MSB 5
`define AOLSR_BIT_CHB_LS 0
`define AOLSR_BIT_CHA_LS 3
`define AOLSR_BIT_LS_SRC 4
`define AOLSR_BIT_BOOST_OVR 7
`define AOLSR_MASK_OFFSET_CTRL 8'hBC
`define AOLSR_MASK_CHB_LS 8'h01
`define AOLSR_MASK_BOOST_OVR 8'h80
`define AOLSR_MASK_LS_SRC 8'h10
`define AOLSR_MASK_SWING_EN 8'h03
`define AOLSR_MASK_CHA_LS 8'h08
`define AOLSR_SWING_OFF 2'h0
`define AOLSR_SWING_ON 2'h3
`define AOLSR_RESP_OKAY 2'h0
`define AOLSR_RESP_SLVERR 2'h2
`endif

// ===== logic/aolsr_pkg.sv
// types of the register slice
package aolsr_pkg;
  typedef enum logic [2:0] {
    AOLSR_W_IDLE = 3'h1,
    AOLSR_W_DATA = 3'h2,
    AOLSR_W_RESP = 3'h4
  } aolsr_wst_t;
  typedef enum logic [1:0] {
    AOLSR_R_IDLE = 2'h1,
    AOLSR_R_RESP = 2'h2
  } aolsr_rst_t;
endpackage

// ===== logic/aolsr_offset_loop.sv
// offset estimate tracker with freeze and programmable time constant
`timescale 1ns/1ps
`include "aolsr_consts.svh"
module aolsr_offset_loop #(
  parameter int DW = 11,
  parameter int TCW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic enable,
  input wire logic hold,
  input wire logic [TCW-1:0] tc,
  // sample in, estimate out
  input wire logic [DW-1:0] sample,
  output logic [DW-1:0] estimate,
  output logic updating
);
  logic [DW-1:0] est_q, est_d;
  logic [15:0] cnt_q, cnt_d;
  logic upd_q, upd_d;

  always_comb begin
    est_d = est_q;
    cnt_d = cnt_q;
    upd_d = 1'b0;
    if (enable && !hold) begin
      if (cnt_q >= {12'h000, tc}) begin
        cnt_d = 16'h0000;
        upd_d = 1'b1;
        if (sample > est_q) est_d = est_q + 1'b1;
        else if (sample < est_q) est_d = est_q - 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end else begin
      cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      est_q <= '0;
      cnt_q <= 16'h0000;
      upd_q <= 1'b0;
    end else begin
      est_q <= est_d;
      cnt_q <= cnt_d;
      upd_q <= upd_d;
    end
  end

  assign estimate = est_q;
  assign updating = upd_q;

  a_hold_freezes_est: assert property (@(posedge clk) disable iff (!nrst)
    (enable && hold) |=> $stable(est_q)) else $error("estimate moved while held");
  a_tc_spacing: assert property (@(posedge clk) disable iff (!nrst)
    upd_q && tc == 4'h2 && $stable(tc) |=> !upd_q) else $error("update too early");
endmodule

// ===== logic/aolsr_regs.sv
// axi4-lite register slice: offset loop, low-speed mode, swing gate, boost override
// What this block does
// - freeze bit 1 holds estimate each cycle; 0 keeps updating; needs loop enable
// - register-controlled: channel B register bit 0 enables channel B low-speed
// - register-controlled: channel A register bit 3 enables channel A low-speed
// - source bit 0 uses serial clock pin dc level; 1 uses register bits
// - swing field 00 disables, 11 enables; software never writes 01 or 10
`timescale 1ns/1ps
`include "aolsr_consts.svh"
module aolsr_regs #(
  parameter int DW = 11
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // axi4-lite write address
  input wire logic [9:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [9:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // converter side
  input wire logic OFFSET_LOOP_ENABLE,
  input wire logic SCLK_PIN_LEVEL,
  input wire logic [DW-1:0] OFFSET_SAMPLE,
  output logic [DW-1:0] OFFSET_ESTIMATE,
  output logic CHAN_A_SLOW_RATE_ENABLE,
  output logic CHAN_B_SLOW_RATE_ENABLE,
  output logic SWING_REG_CONTROL,
  output logic NOISE_SHAPER_PIN_OVERRIDE
);
  logic [7:0] ctrl_q, ctrl_d, chb_q, chb_d, ovr_q, ovr_d;
  logic [7:0] src_q, src_d, swg_q, swg_d, cha_q, cha_d;
  aolsr_pkg::aolsr_wst_t wst_q, wst_d;
  aolsr_pkg::aolsr_rst_t rst_q, rst_d;
  logic [9:0] waddr_q, waddr_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic slowa_q, slowa_d, slowb_q, slowb_d, swon_q, swon_d, upd;
  logic [DW-1:0] est;

  // unaligned byte addresses never match a register
  function automatic logic mapped(input logic [9:0] a);
    mapped = a == `AOLSR_ADR_OFFSET_CTRL || a == `AOLSR_ADR_CHB_LS ||
      a == `AOLSR_ADR_BOOST_OVR || a == `AOLSR_ADR_LS_SRC ||
      a == `AOLSR_ADR_SWING_EN || a == `AOLSR_ADR_CHA_LS;
  endfunction

  aolsr_offset_loop #(.DW(DW), .TCW(4)) u_loop (
    .clk(CLK),
    .nrst(NRST),
    .enable(OFFSET_LOOP_ENABLE),
    .hold(ctrl_q[`AOLSR_BIT_HOLD]),
    .tc(ctrl_q[`AOLSR_TC_MSB:`AOLSR_TC_LSB]),
    .sample(OFFSET_SAMPLE),
    .estimate(est),
    .updating(upd)
  );

  // write channel: address taken first, then data, one at a time
  always_comb begin
    wst_d = wst_q;
    waddr_d = waddr_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    chb_d = chb_q;
    ovr_d = ovr_q;
    src_d = src_q;
    swg_d = swg_q;
    cha_d = cha_q;
    case (wst_q)
      aolsr_pkg::AOLSR_W_IDLE: begin
        if (S_AXI_AWVALID) begin
          waddr_d = S_AXI_AWADDR;
          wst_d = aolsr_pkg::AOLSR_W_DATA;
        end
      end
      aolsr_pkg::AOLSR_W_DATA: begin
        if (S_AXI_WVALID) begin
          wst_d = aolsr_pkg::AOLSR_W_RESP;
          bresp_d = mapped(waddr_q) ? `AOLSR_RESP_OKAY : `AOLSR_RESP_SLVERR;
          if (S_AXI_WSTRB[0]) begin
            case (waddr_q)
              `AOLSR_ADR_OFFSET_CTRL: ctrl_d = S_AXI_WDATA[7:0] & `AOLSR_MASK_OFFSET_CTRL;
              `AOLSR_ADR_CHB_LS: chb_d = S_AXI_WDATA[7:0] & `AOLSR_MASK_CHB_LS;
              `AOLSR_ADR_BOOST_OVR: ovr_d = S_AXI_WDATA[7:0] & `AOLSR_MASK_BOOST_OVR;
              `AOLSR_ADR_LS_SRC: src_d = S_AXI_WDATA[7:0] & `AOLSR_MASK_LS_SRC;
              `AOLSR_ADR_SWING_EN: swg_d = S_AXI_WDATA[7:0] & `AOLSR_MASK_SWING_EN;
              `AOLSR_ADR_CHA_LS: cha_d = S_AXI_WDATA[7:0] & `AOLSR_MASK_CHA_LS;
              default: ;
            endcase
          end
        end
      end
      aolsr_pkg::AOLSR_W_RESP: begin
        if (S_AXI_BREADY) wst_d = aolsr_pkg::AOLSR_W_IDLE;
      end
      default: wst_d = aolsr_pkg::AOLSR_W_IDLE;
    endcase
  end

  // read channel
  always_comb begin
    rst_d = rst_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rst_q)
      aolsr_pkg::AOLSR_R_IDLE: begin
        if (S_AXI_ARVALID) begin
          rst_d = aolsr_pkg::AOLSR_R_RESP;
          rresp_d = `AOLSR_RESP_OKAY;
          rdata_d = 32'h00000000;
          case (S_AXI_ARADDR)
            `AOLSR_ADR_OFFSET_CTRL: rdata_d[7:0] = ctrl_q;
            `AOLSR_ADR_CHB_LS: rdata_d[7:0] = chb_q;
            `AOLSR_ADR_BOOST_OVR: rdata_d[7:0] = ovr_q;
            `AOLSR_ADR_LS_SRC: rdata_d[7:0] = src_q;
            `AOLSR_ADR_SWING_EN: rdata_d[7:0] = swg_q;
            `AOLSR_ADR_CHA_LS: rdata_d[7:0] = cha_q;
            `AOLSR_ADR_STATUS:
              rdata_d = {5'h00, est, 12'h000, swon_q, slowb_q, slowa_q, upd};
            default: rresp_d = `AOLSR_RESP_SLVERR;
          endcase
        end
      end
      aolsr_pkg::AOLSR_R_RESP: begin
        if (S_AXI_RREADY) rst_d = aolsr_pkg::AOLSR_R_IDLE;
      end
      default: rst_d = aolsr_pkg::AOLSR_R_IDLE;
    endcase
  end

  // mode outputs
  always_comb begin
    // pin level or register bits choose low-speed mode
    if (src_q[`AOLSR_BIT_LS_SRC]) begin
      slowa_d = cha_q[`AOLSR_BIT_CHA_LS];
      slowb_d = chb_q[`AOLSR_BIT_CHB_LS];
    end else begin
      slowa_d = SCLK_PIN_LEVEL;
      slowb_d = SCLK_PIN_LEVEL;
    end
    swon_d = swg_q[1:0] == `AOLSR_SWING_ON;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wst_q <= aolsr_pkg::AOLSR_W_IDLE;
      rst_q <= aolsr_pkg::AOLSR_R_IDLE;
      waddr_q <= 10'h000;
      bresp_q <= 2'h0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h00000000;
      ctrl_q <= `AOLSR_RST_VAL;
      chb_q <= `AOLSR_RST_VAL;
      ovr_q <= `AOLSR_RST_VAL;
      src_q <= `AOLSR_RST_VAL;
      swg_q <= `AOLSR_RST_VAL;
      cha_q <= `AOLSR_RST_VAL;
      slowa_q <= 1'b0;
      slowb_q <= 1'b0;
      swon_q <= 1'b0;
    end else begin
      wst_q <= wst_d;
      rst_q <= rst_d;
      waddr_q <= waddr_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      chb_q <= chb_d;
      ovr_q <= ovr_d;
      src_q <= src_d;
      swg_q <= swg_d;
      cha_q <= cha_d;
      slowa_q <= slowa_d;
      slowb_q <= slowb_d;
      swon_q <= swon_d;
    end
  end

  // one-hot state bits drive the handshake outputs straight from the flops
  assign S_AXI_AWREADY = wst_q[0];
  assign S_AXI_WREADY = wst_q[1];
  assign S_AXI_BVALID = wst_q[2];
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = rst_q[0];
  assign S_AXI_RVALID = rst_q[1];
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign OFFSET_ESTIMATE = est;
  assign CHAN_A_SLOW_RATE_ENABLE = slowa_q;
  assign CHAN_B_SLOW_RATE_ENABLE = slowb_q;
  assign SWING_REG_CONTROL = swon_q;
  assign NOISE_SHAPER_PIN_OVERRIDE = ovr_q[`AOLSR_BIT_BOOST_OVR];

  a_chb_reg_mode: assert property (@(posedge CLK) disable iff (!NRST)
    src_q[4] |=> slowb_q == $past(chb_q[0])) else $error("chan B mode wrong");
  a_cha_reg_mode: assert property (@(posedge CLK) disable iff (!NRST)
    src_q[4] |=> slowa_q == $past(cha_q[3])) else $error("chan A mode wrong");
  a_pin_mode: assert property (@(posedge CLK) disable iff (!NRST)
    !src_q[4] |=> slowa_q == $past(SCLK_PIN_LEVEL) && slowb_q == slowa_q)
    else $error("pin mode wrong");
  a_swing_gate: assert property (@(posedge CLK) disable iff (!NRST)
    swg_q[1:0] != 2'h3 |=> !swon_q) else $error("swing enabled wrongly");
  a_unused_zero: assert property (@(posedge CLK) disable iff (!NRST)
    ctrl_q[6] == 1'b0 && ctrl_q[1:0] == 2'h0 && src_q[3:0] == 4'h0)
    else $error("reserved bit stored");
  a_hold_loop: assert property (@(posedge CLK) disable iff (!NRST)
    ctrl_q[7] && OFFSET_LOOP_ENABLE ##1 ctrl_q[7] |-> !upd) else $error("frozen loop updated");
  a_tc_field: assert property (@(posedge CLK) disable iff (!NRST)
    upd && ctrl_q[`AOLSR_TC_MSB:`AOLSR_TC_LSB] != 4'h0 |=> !upd)
    else $error("back to back updates");
  a_write_resp: assert property (@(posedge CLK) disable iff (!NRST)
    S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID) else $error("no write response");
  c_reg_write: cover property (@(posedge CLK) S_AXI_BVALID && S_AXI_BREADY);
  c_reg_read: cover property (@(posedge CLK) S_AXI_RVALID && S_AXI_RREADY);
  c_reg_mode: cover property (@(posedge CLK) src_q[4] && slowa_q);
  c_swing_on: cover property (@(posedge CLK) swon_q);
endmodule

// ===== dv/tb.sv
// self-checking testbench of the register slice
`timescale 1ns/1ps
`include "aolsr_consts.svh"
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  // response channels are always accepted
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic lpen = 1'b0, pin = 1'b0;
  logic [10:0] smp = 11'h000, est;
  logic lsa, lsb, swg, ovr;
  int errors = 0, samples_checked = 0, cycles = 0;
  logic [7:0] ofs [6] = '{`AOLSR_OFS_OFFSET_CTRL, `AOLSR_OFS_CHB_LS, `AOLSR_OFS_BOOST_OVR,
    `AOLSR_OFS_LS_SRC, `AOLSR_OFS_SWING_EN, `AOLSR_OFS_CHA_LS};
  logic [7:0] msk [6] = '{`AOLSR_MASK_OFFSET_CTRL, `AOLSR_MASK_CHB_LS, `AOLSR_MASK_BOOST_OVR,
    `AOLSR_MASK_LS_SRC, `AOLSR_MASK_SWING_EN, `AOLSR_MASK_CHA_LS};
  int tcs [3] = '{0, 3, 15};

  always #4 clk = ~clk;

  aolsr_regs #(.DW(11)) i_dut (.CLK(clk), .NRST(nrst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .OFFSET_LOOP_ENABLE(lpen), .SCLK_PIN_LEVEL(pin), .OFFSET_SAMPLE(smp),
    .OFFSET_ESTIMATE(est), .CHAN_A_SLOW_RATE_ENABLE(lsa), .CHAN_B_SLOW_RATE_ENABLE(lsb),
    .SWING_REG_CONTROL(swg), .NOISE_SHAPER_PIN_OVERRIDE(ovr));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  // address and data offered together, each released once taken
  // a is the register index; the bus carries the byte address, four times it
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, tk;
    tk = 1'b0;
    r = 2'h1;
    awaddr <= {a, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tk) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tk = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tk;
    tk = 1'b0;
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    while (!tk) begin
      @(negedge clk);
      ta = arvalid & arready;
      tk = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
  endtask

  function automatic logic exp_ls(input logic src, input logic bit_v, input logic lvl);
    return src ? bit_v : lvl;
  endfunction

  initial begin
    logic [31:0] d, v;
    logic [1:0] r;
    logic [10:0] e0;
    int ex, df;
    void'($urandom(30346));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], d, r);
      check(d, {24'h0, `AOLSR_RST_VAL});
      check({30'h0, r}, {30'h0, `AOLSR_RESP_OKAY});
    end
    for (int i = 0; i < 6; i++) begin
      v = $urandom & {24'h0, msk[i]};
      wr(ofs[i], v, 4'hF, r);
      rd(ofs[i], d, r);
      check(d, v);
    end
    // strobe low must leave the register alone
    wr(ofs[5], v ^ {24'h0, msk[5]}, 4'h0, r);
    rd(ofs[5], d, r);
    check(d, v);
    wr(8'h00, $urandom, 4'hF, r);
    check({30'h0, r}, {30'h0, `AOLSR_RESP_SLVERR});
    rd(8'h00, d, r);
    check({22'h0, r, d[7:0]}, {22'h0, `AOLSR_RESP_SLVERR, 8'h00});
    for (int i = 0; i < 16; i++) begin
      wr(`AOLSR_OFS_LS_SRC, {27'h0, i[0], 4'h0}, 4'hF, r);
      wr(`AOLSR_OFS_CHA_LS, {28'h0, i[1], 3'h0}, 4'hF, r);
      wr(`AOLSR_OFS_CHB_LS, {31'h0, i[2]}, 4'hF, r);
      pin <= i[3];
      repeat (3) @(posedge clk);
      check({31'h0, lsa}, {31'h0, exp_ls(i[0], i[1], i[3])});
      check({31'h0, lsb}, {31'h0, exp_ls(i[0], i[2], i[3])});
    end
    // only 00 and 11 are ever written to the swing field
    for (int i = 0; i < 4; i++) begin
      wr(`AOLSR_OFS_SWING_EN, {30'h0, {2{i[0]}}}, 4'hF, r);
      repeat (3) @(posedge clk);
      check({31'h0, swg}, {31'h0, i[0]});
    end
    // register mode with both channel bits set, swing on, loop idle
    rd(`AOLSR_OFS_STATUS, d, r);
    check(d, 32'h0000000E);
    for (int i = 1; i >= 0; i--) begin
      wr(`AOLSR_OFS_BOOST_OVR, {24'h0, i[0], 7'h0}, 4'hF, r);
      repeat (3) @(posedge clk);
      check({31'h0, ovr}, {31'h0, i[0]});
    end
    smp <= 11'(32'h400 + ($urandom & 32'h3FF));
    lpen <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wr(`AOLSR_OFS_OFFSET_CTRL, tcs[k] << 2, 4'hF, r);
      repeat (4) @(posedge clk);
      e0 = est;
      repeat (48) @(posedge clk);
      df = int'(est) - int'(e0);
      ex = 48 / (tcs[k] + 1);
      check(32'(df >= ex - 1 && df <= ex + 1), 32'h1);
    end
    wr(`AOLSR_OFS_OFFSET_CTRL, 32'h8C, 4'hF, r);
    repeat (4) @(posedge clk);
    e0 = est;
    repeat (40) @(posedge clk);
    check({21'h0, est}, {21'h0, e0});
    lpen <= 1'b0;
    wr(`AOLSR_OFS_OFFSET_CTRL, 32'h0C, 4'hF, r);
    repeat (4) @(posedge clk);
    e0 = est;
    repeat (40) @(posedge clk);
    check({21'h0, est}, {21'h0, e0});
    conclude();
  end
endmodule
